// ==== core/fcc_cpu.sv ====
// Purpose: CPU end that runs one command sequence on request
// Assumes: Divider value chosen by the user meets array timing limits
// Notes: Writes divider once, clears errors, then polls for completion
`timescale 1ns/100ps
`default_nettype none
module fcc_cpu
    import fcc_pkg::*;
(
    fcc_if.cpu bus,
    input wire logic go_i,
    input wire logic [fcc_pkg::DW-1:0] cmd_i,
    input wire logic [fcc_pkg::AW-1:0] addr_i,
    input wire logic [fcc_pkg::DW-1:0] data_i,
    input wire logic [fcc_pkg::DW-1:0] div_i,
    output logic busy_o,
    output logic done_o,
    output logic err_o
);
    import fcc_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE, H_DIV, H_CLR, H_ARR, H_CMD, H_GO, H_POLL, H_WAIT
    } host_e;

    logic clk;
    logic rstn;
    assign clk = bus.clk_i;
    assign rstn = bus.rstn_i;

    host_e st_reg;
    logic div_done_reg;
    logic [DW-1:0] cmd_reg, data_reg;
    logic [AW-1:0] addr_reg;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= H_IDLE;
            div_done_reg <= 1'b0;
            cmd_reg <= '0;
            data_reg <= '0;
            addr_reg <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            err_o <= 1'b0;
            bus.req <= 1'b0;
            bus.we <= 1'b0;
            bus.arr_sel <= 1'b0;
            bus.addr <= '0;
            bus.wdata <= '0;
        end
        else
        begin
            bus.req <= 1'b0;
            done_o <= 1'b0;
            unique case (st_reg)
                H_IDLE:
                    if (go_i)
                    begin
                        cmd_reg <= cmd_i;
                        addr_reg <= addr_i;
                        data_reg <= data_i;
                        busy_o <= 1'b1;
                        err_o <= 1'b0;
                        st_reg <= div_done_reg ? H_CLR : H_DIV;
                    end
                H_DIV:
                begin
                    bus.req <= 1'b1;
                    bus.we <= 1'b1;
                    bus.arr_sel <= 1'b0;
                    bus.addr <= AW'(OFS_DIV);
                    bus.wdata <= div_i; // [R3] [R4] [R5]
                    div_done_reg <= 1'b1;
                    st_reg <= H_CLR;
                end
                H_CLR:
                begin
                    // Stale errors would block the sequence
                    bus.req <= 1'b1;
                    bus.we <= 1'b1;
                    bus.arr_sel <= 1'b0;
                    bus.addr <= AW'(OFS_STAT);
                    bus.wdata <= 8'h30; // [R6]
                    st_reg <= H_ARR;
                end
                H_ARR:
                begin
                    bus.req <= 1'b1;
                    bus.we <= 1'b1;
                    bus.arr_sel <= 1'b1;
                    bus.addr <= addr_reg; // [R8]
                    bus.wdata <= data_reg;
                    st_reg <= H_CMD;
                end
                H_CMD:
                begin
                    bus.req <= 1'b1;
                    bus.we <= 1'b1;
                    bus.arr_sel <= 1'b0;
                    bus.addr <= AW'(OFS_CMD); // [R8]
                    bus.wdata <= cmd_reg;
                    st_reg <= H_GO;
                end
                H_GO:
                begin
                    bus.req <= 1'b1;
                    bus.we <= 1'b1;
                    bus.arr_sel <= 1'b0;
                    bus.addr <= AW'(OFS_STAT);
                    bus.wdata <= 8'h80; // [R9]
                    st_reg <= H_POLL;
                end
                H_POLL:
                begin
                    bus.req <= 1'b1;
                    bus.we <= 1'b0;
                    bus.arr_sel <= 1'b0;
                    bus.addr <= AW'(OFS_STAT);
                    st_reg <= H_WAIT;
                end
                H_WAIT:
                    if (bus.rvalid)
                    begin
                        if (bus.rdata[ST_ACCESS_ERROR_FLAG] || bus.rdata[ST_PROTECTION_VIOLATION_FLAG])
                        begin
                            err_o <= 1'b1;
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                            st_reg <= H_IDLE;
                        end
                        else if (bus.rdata[ST_DONE])
                        begin
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                            st_reg <= H_IDLE;
                        end
                        else
                            st_reg <= H_POLL;
                    end
            endcase
        end
    end
endmodule // fcc_cpu
`default_nettype wire

// ==== core/fcc_ctrl.sv ====
// Purpose: Array command controller, device end
// Assumes: CPU keeps the three-step order and clears errors first
// Notes: One command active, one buffered behind it
// Summary of operation
// [R1] Divider write sets divider-loaded flag
// [R2] Launch without divider write raises access error
// [R3] Software avoids program/erase below 1 MHz bus
// [R4] Software keeps timing clock at least 150 kHz
// [R5] Timing plus bus period at least 5 us
// [R6] Software clears errors, checks buffer-empty first; the CPU end clears errors but never reads buffer-empty
// [R7] New sequence while buffer full overwrites buffers
// [R8] Host order: array write, command, launch
// [R9] Writing 1 to buffer-empty launches, clears it
// [R10] Step-one address and data are held
// [R11] Launch clears complete, then buffer-empty sets
// [R12] Buffered command waits for active one
// [R13] Complete sets when all commands finished
// [R14] Backdoor enabled only for value 10
// [R15] Unsecured only for security value 10
// [R16] Backdoor unsecure forces security field 10
// [R17] Bits 5..2 are user nonvolatile flags
// [R18] Software prefers 01 for disabled and secured
// [R19] Reserved factory register reads zero, ignores writes
// [R20] Protection loaded from 0xFF0D during reset
// [R21] Foreign write mid-sequence aborts, sets access error
`timescale 1ns/100ps
`default_nettype none
module fcc_ctrl
    import fcc_pkg::*;
#(
    parameter int OP_LEN = OP_TICKS
)
(
    fcc_if.dev bus,
    input wire logic [fcc_pkg::DW-1:0] nv_sec_i,
    input wire logic [fcc_pkg::DW-1:0] nv_prot_i,
    input wire logic unlock_i,
    output logic op_start_o,
    output logic op_busy_o,
    output logic [fcc_pkg::DW-1:0] op_cmd_o,
    output logic [fcc_pkg::AW-1:0] op_addr_o,
    output logic [fcc_pkg::DW-1:0] op_data_o,
    output logic key_enable_o,
    output logic secured_o,
    output logic [3:0] user_flags_o,
    output logic [fcc_pkg::DW-1:0] prot_o
);
    import fcc_pkg::*;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADDR, SEQ_CMD} seq_e;

    logic clk;
    logic rstn;
    assign clk = bus.clk_i;
    assign rstn = bus.rstn_i;

    seq_e seq_reg;
    logic boot_reg;
    logic div_loaded_reg;
    logic [DIV_W-1:0] timing_divider_reg;
    logic [DW-1:0] sec_reg;
    logic [DW-1:0] protection_config_reg;
    logic bempty_reg, done_reg, protection_violation_flag_reg, access_error_flag_reg;
    logic [AW-1:0] address_hold_regs;
    logic [DW-1:0] data_hold_regs;
    logic [DW-1:0] command_code_reg;
    logic pend_reg;
    logic act_reg;
    logic [DIV_W-1:0] pre_reg;
    logic [7:0] tick_reg;

    logic wr, rd, reg_wr, arr_wr, launch, valid_cmd, act_end, take;
    logic mass_blocked, step_err, start, accept;
    assign wr = bus.req && bus.we;
    assign rd = bus.req && !bus.we;
    assign reg_wr = wr && !bus.arr_sel;
    assign arr_wr = wr && bus.arr_sel;
    assign launch = reg_wr && bus.addr[RAW-1:0] == OFS_STAT
        && bus.wdata[ST_BEMPTY] && seq_reg == SEQ_CMD; // [R9]
    assign valid_cmd = bus.wdata == CMD_VERIFY || bus.wdata == CMD_PROG
        || bus.wdata == CMD_ERASE || bus.wdata == CMD_MASS;
    // Mass erase needs every range opened
    assign mass_blocked = command_code_reg == CMD_MASS
        && !(protection_config_reg[PR_OPEN] && protection_config_reg[PR_HDIS]
        && protection_config_reg[PR_LDIS]);
    // Any module write that is not the expected next step
    assign step_err = wr && seq_reg != SEQ_IDLE && !launch
        && !(seq_reg == SEQ_ADDR && reg_wr
        && bus.addr[RAW-1:0] == OFS_CMD && valid_cmd); // [R21]
    assign act_end = act_reg && tick_reg == 8'(OP_LEN);
    assign take = pend_reg && (!act_reg || act_end) && boot_reg; // [R12]
    assign start = seq_reg == SEQ_IDLE && arr_wr && !access_error_flag_reg && !protection_violation_flag_reg;
    assign accept = launch && div_loaded_reg && !mass_blocked;

    // Reset sequence: nonvolatile bytes are caught after release
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            boot_reg <= 1'b0;
            protection_config_reg <= RESET_BYTE;
        end
        else if (!boot_reg)
        begin
            boot_reg <= 1'b1;
            protection_config_reg <= nv_prot_i; // [R20]
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            sec_reg <= RESET_BYTE;
        else if (!boot_reg)
            sec_reg <= nv_sec_i;
        else if (unlock_i)
            sec_reg[SECF_HI:SECF_LO] <= SEC_OPEN; // [R16]
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_loaded_reg <= 1'b0;
            timing_divider_reg <= '0;
        end
        else if (reg_wr && bus.addr[RAW-1:0] == OFS_DIV)
        begin
            div_loaded_reg <= 1'b1; // [R1]
            timing_divider_reg <= bus.wdata[DIV_W-1:0];
        end
    end

    // Three-step write sequence
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            seq_reg <= SEQ_IDLE;
        else if (step_err || launch)
            seq_reg <= SEQ_IDLE;
        else if (start)
            seq_reg <= SEQ_ADDR;
        else if (seq_reg == SEQ_ADDR && reg_wr)
            seq_reg <= SEQ_CMD;
    end

    // Buffer capture; a new step one overwrites a waiting command
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            address_hold_regs <= '0;
            data_hold_regs <= '0;
            command_code_reg <= '0;
        end
        else if (start)
        begin
            address_hold_regs <= bus.addr; // [R10] [R7]
            data_hold_regs <= bus.wdata; // [R10] [R7]
        end
        else if (seq_reg == SEQ_ADDR && reg_wr && !step_err)
            command_code_reg <= bus.wdata; // [R7]
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            pend_reg <= 1'b0;
        else if (accept)
            pend_reg <= 1'b1;
        else if (take || start)
            pend_reg <= 1'b0; // [R7]
    end

    // Timing clock: one tick per divider+1 bus clocks
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            act_reg <= 1'b0;
            pre_reg <= '0;
            tick_reg <= '0;
        end
        else if (take)
        begin
            act_reg <= 1'b1;
            pre_reg <= '0;
            tick_reg <= '0;
        end
        else if (act_end)
            act_reg <= 1'b0;
        else if (act_reg)
        begin
            if (pre_reg == timing_divider_reg)
            begin
                pre_reg <= '0;
                tick_reg <= tick_reg + 8'h01;
            end
            else
                pre_reg <= pre_reg + 7'h01;
        end
    end

    // Flags; an error-flag set wins over a software clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bempty_reg <= 1'b1;
            done_reg <= 1'b1;
            access_error_flag_reg <= 1'b0;
            protection_violation_flag_reg <= 1'b0;
        end
        else
        begin
            if (accept)
            begin
                bempty_reg <= 1'b0; // [R9]
                done_reg <= 1'b0; // [R11]
            end
            else if (start && pend_reg)
                bempty_reg <= 1'b0;
            else if (take)
                bempty_reg <= 1'b1; // [R11]
            else if (!pend_reg && !act_reg)
                bempty_reg <= 1'b1;
            if (act_end && !pend_reg && !accept)
                done_reg <= 1'b1; // [R13]
            if ((launch && !div_loaded_reg) || step_err)
                access_error_flag_reg <= 1'b1; // [R2] [R21]
            else if (reg_wr && bus.addr[RAW-1:0] == OFS_STAT
                && bus.wdata[ST_ACCESS_ERROR_FLAG])
                access_error_flag_reg <= 1'b0;
            if (launch && div_loaded_reg && mass_blocked)
                protection_violation_flag_reg <= 1'b1;
            else if (reg_wr && bus.addr[RAW-1:0] == OFS_STAT
                && bus.wdata[ST_PROTECTION_VIOLATION_FLAG])
                protection_violation_flag_reg <= 1'b0;
        end
    end

    // Register reads, one cycle latency
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bus.rvalid <= 1'b0;
            bus.rdata <= '0;
        end
        else
        begin
            bus.rvalid <= rd;
            bus.rdata <= '0; // [R19]
            if (rd && !bus.arr_sel)
            begin
                unique case (bus.addr[RAW-1:0])
                    OFS_DIV: bus.rdata <= {div_loaded_reg, timing_divider_reg};
                    OFS_SEC: bus.rdata <= sec_reg;
                    OFS_PROT: bus.rdata <= protection_config_reg;
                    OFS_STAT: bus.rdata <= {bempty_reg, done_reg, protection_violation_flag_reg,
                        access_error_flag_reg, 4'h0};
                    OFS_CMD: bus.rdata <= command_code_reg;
                    default: bus.rdata <= '0;
                endcase
            end
        end
    end

    // Array and security outputs
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            op_start_o <= 1'b0;
            op_busy_o <= 1'b0;
            op_cmd_o <= '0;
            op_addr_o <= '0;
            op_data_o <= '0;
            key_enable_o <= 1'b0;
            secured_o <= 1'b1;
            user_flags_o <= '0;
            prot_o <= '0;
        end
        else
        begin
            op_start_o <= take;
            op_busy_o <= act_reg && !act_end || take;
            if (take)
            begin
                op_cmd_o <= command_code_reg;
                op_addr_o <= address_hold_regs;
                op_data_o <= data_hold_regs;
            end
            key_enable_o <= sec_reg[KEY_HI:KEY_LO] == KEY_ON; // [R14]
            secured_o <= sec_reg[SECF_HI:SECF_LO] != SEC_OPEN; // [R15]
            user_flags_o <= sec_reg[NV_HI:NV_LO]; // [R17]
            prot_o <= protection_config_reg;
        end
    end
endmodule // fcc_ctrl
`default_nettype wire

// ==== core/fcc_if.sv ====
// Purpose: Register and array access path between CPU end and controller
// Assumes: Single clock, one request per cycle at most
// Notes: Read data returns one cycle after the read request
`timescale 1ns/100ps
`default_nettype none
interface fcc_if
    import fcc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i
);
    logic req;
    logic we;
    logic arr_sel;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic rvalid;
    logic [DW-1:0] rdata;
    modport dev (
        input clk_i, rstn_i, req, we, arr_sel, addr, wdata,
        output rvalid, rdata
    );
    modport cpu (
        input clk_i, rstn_i, rvalid, rdata,
        output req, we, arr_sel, addr, wdata
    );
endinterface
`default_nettype wire

// ==== core/fcc_pkg.sv ====
// Purpose: Shared constants for the array command controller and its CPU end
// Assumes: 8-bit register data, 16-bit array addresses
// Notes: Register offsets sit in the low address bits of a register access
package fcc_pkg;
    localparam int AW = 16;
    localparam int DW = 8;
    localparam int RAW = 4;
    // Register offsets
    localparam logic [RAW-1:0] OFS_DIV = 4'h0;
    localparam logic [RAW-1:0] OFS_SEC = 4'h1;
    localparam logic [RAW-1:0] OFS_RSV = 4'h2;
    localparam logic [RAW-1:0] OFS_PROT = 4'h4;
    localparam logic [RAW-1:0] OFS_STAT = 4'h5;
    localparam logic [RAW-1:0] OFS_CMD = 4'h6;
    // Status bit positions
    localparam int ST_BEMPTY = 7;
    localparam int ST_DONE = 6;
    localparam int ST_PROTECTION_VIOLATION_FLAG = 5;
    localparam int ST_ACCESS_ERROR_FLAG = 4;
    // Divider register layout
    localparam int DIV_LOADED = 7;
    localparam int DIV_W = 7;
    // Security byte layout
    localparam int KEY_HI = 7;
    localparam int KEY_LO = 6;
    localparam int NV_HI = 5;
    localparam int NV_LO = 2;
    localparam int SECF_HI = 1;
    localparam int SECF_LO = 0;
    localparam logic [1:0] KEY_ON = 2'h2;
    localparam logic [1:0] SEC_OPEN = 2'h2;
    localparam logic [1:0] PREFER_OFF = 2'h1;
    // Protection byte layout and its nonvolatile home
    localparam int PR_OPEN = 7;
    localparam int PR_HDIS = 5;
    localparam int PR_LDIS = 2;
    localparam logic [AW-1:0] PROT_NV_ADDR = 16'hFF0D;
    // Command codes
    localparam logic [DW-1:0] CMD_VERIFY = 8'h05;
    localparam logic [DW-1:0] CMD_PROG = 8'h20;
    localparam logic [DW-1:0] CMD_ERASE = 8'h40;
    localparam logic [DW-1:0] CMD_MASS = 8'h41;
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int MIN_BUS_HZ = 1_000_000;
    localparam int MIN_TCLK_HZ = 150_000;
    localparam int MIN_TSUM_US = 5;
    localparam int OP_TICKS = 20;
    localparam logic [DW-1:0] RESET_BYTE = 8'h00;
endpackage

// ==== tb/fcc_props.sv ====
// Purpose: Protocol checks on the bus joining CPU end and controller
// Assumes: Only the interface signals are visible here
// Notes: Helper flops track sequence step and time since launch
`timescale 1ns/100ps
`default_nettype none
module fcc_props
    import fcc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic req,
    input wire logic we,
    input wire logic arr_sel,
    input wire logic [fcc_pkg::AW-1:0] addr,
    input wire logic [fcc_pkg::DW-1:0] wdata,
    input wire logic rvalid,
    input wire logic [fcc_pkg::DW-1:0] rdata
);
    logic [1:0] step_reg;
    logic [3:0] age_reg;
    logic div_reg;
    logic clr_reg;
    wire logic reg_wr = req && we && !arr_sel;
    wire logic arr_wr = req && we && arr_sel;
    wire logic stat_wr = reg_wr && addr[3:0] == OFS_STAT;
    wire logic launch = stat_wr && wdata[ST_BEMPTY];
    wire logic stat_rd = req && !we && !arr_sel && addr[3:0] == OFS_STAT;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            step_reg <= 2'h0;
        else if (arr_wr)
            step_reg <= 2'h1;
        else if (reg_wr)
            step_reg <= (step_reg == 2'h1) ? 2'h2 : 2'h0;
    end
    // Saturates so old launches never re-arm the window
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            age_reg <= 4'h0;
        else if (launch)
            age_reg <= 4'h1;
        else if (age_reg != 4'h0 && age_reg != 4'hF)
            age_reg <= age_reg + 4'h1;
    end
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            div_reg <= 1'b0;
        else if (reg_wr && addr[3:0] == OFS_DIV)
            div_reg <= 1'b1;
    end
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            clr_reg <= 1'b0;
        else if (launch)
            clr_reg <= 1'b0;
        else if (stat_wr && wdata[ST_PROTECTION_VIOLATION_FLAG] && wdata[ST_ACCESS_ERROR_FLAG])
            clr_reg <= 1'b1;
    end
    sequence s_read;
        req && !we;
    endsequence
    // Buffer emptied by now, long operation still running
    sequence s_early_poll;
        stat_rd && age_reg >= 4'h3 && age_reg <= 4'h8;
    endsequence
    property p_read_answer;
        s_read |=> rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read without answer");
    property p_no_stray;
        rvalid |-> $past(req && !we);
    endproperty
    a_no_stray: assert property (p_no_stray)
        else $error("answer without read");
    property p_rdata_idle;
        !rvalid |-> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not cleared");
    property p_launch_flags;
        s_early_poll |=> rdata[ST_BEMPTY] && !rdata[ST_DONE];
    endproperty
    a_launch_flags: assert property (p_launch_flags)
        else $error("flags wrong after launch");
    property p_cmd_after_arr;
        (reg_wr || arr_wr) && step_reg == 2'h1 |-> addr[3:0] == OFS_CMD;
    endproperty
    a_cmd_after_arr: assert property (p_cmd_after_arr)
        else $error("step two is not a command write");
    property p_launch_after_cmd;
        (reg_wr || arr_wr) && step_reg == 2'h2 |-> launch;
    endproperty
    a_launch_after_cmd: assert property (p_launch_after_cmd)
        else $error("step three is not a launch");
    property p_div_first;
        launch |-> div_reg;
    endproperty
    a_div_first: assert property (p_div_first)
        else $error("launch before divider write");
    property p_clear_first;
        arr_wr |-> clr_reg;
    endproperty
    a_clear_first: assert property (p_clear_first)
        else $error("sequence started without clearing errors");
endmodule // fcc_props
`default_nettype wire

// ==== tb/flash_command_controller_test.sv ====
// Purpose: Self-checking run of controller and CPU end
// Assumes: OP_LEN of 2 with a large divider keeps operations long enough
// Notes: Second bus is driven by the bench to break the sequence
`timescale 1ns/100ps
`default_nettype none
module flash_command_controller_test;
    import fcc_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic go = 1'b0;
    logic [DW-1:0] cmd = 8'h00;
    logic [AW-1:0] adr = 16'h0000;
    logic [DW-1:0] dat = 8'h00;
    logic [DW-1:0] nv_sec = 8'h00;
    logic [DW-1:0] nv_prot = 8'h5C;
    logic unlock = 1'b0;
    logic done;
    logic busy1;
    logic err;
    logic [DW-1:0] cmd1;
    logic [DW-1:0] dat1;
    logic [AW-1:0] adr1;
    logic start2;
    logic busy2;
    logic key2;
    logic sec2;
    logic [3:0] flags2;
    logic [DW-1:0] cmd2;
    logic [DW-1:0] dat2;
    logic [DW-1:0] prot2;
    logic [AW-1:0] adr2;
    int n_mismatch = 0;
    int checks_done = 0;
    always #5 clk_i = ~clk_i;
    fcc_if bus1(.clk_i(clk_i), .rstn_i(rstn_i));
    fcc_if bus2(.clk_i(clk_i), .rstn_i(rstn_i));
    fcc_cpu fcc_cpu_inst(.bus(bus1), .go_i(go), .cmd_i(cmd), .addr_i(adr),
        .data_i(dat), .div_i(8'h07), .busy_o(busy1), .done_o(done),
        .err_o(err));
    fcc_ctrl #(.OP_LEN(2)) fcc_ctrl_inst(.bus(bus1), .nv_sec_i(nv_sec),
        .nv_prot_i(nv_prot), .unlock_i(unlock), .op_start_o(), .op_busy_o(),
        .op_cmd_o(cmd1), .op_addr_o(adr1), .op_data_o(dat1),
        .key_enable_o(), .secured_o(), .user_flags_o(), .prot_o());
    fcc_ctrl #(.OP_LEN(2)) fcc_ctrl_inst2(.bus(bus2), .nv_sec_i(nv_sec),
        .nv_prot_i(nv_prot), .unlock_i(unlock), .op_start_o(start2),
        .op_busy_o(busy2), .op_cmd_o(cmd2), .op_addr_o(adr2),
        .op_data_o(dat2), .key_enable_o(key2), .secured_o(sec2),
        .user_flags_o(flags2), .prot_o(prot2));
    fcc_props fcc_props_inst(.clk_i(clk_i), .rstn_i(rstn_i),
        .req(bus1.req), .we(bus1.we), .arr_sel(bus1.arr_sel),
        .addr(bus1.addr), .wdata(bus1.wdata), .rvalid(bus1.rvalid),
        .rdata(bus1.rdata));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
        input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One request per call, always an idle cycle before the next
    task automatic access(input logic a, input logic w,
        input logic [15:0] ad, input logic [7:0] d);
        @(negedge clk_i);
        {bus2.req, bus2.we, bus2.arr_sel, bus2.addr, bus2.wdata} =
            {1'b1, w, a, ad, d};
        @(negedge clk_i);
        bus2.req = 1'b0;
    endtask
    task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
        access(1'b0, 1'b1, {12'h000, ofs}, d);
    endtask
    task automatic rd(input logic [3:0] ofs, input logic [7:0] mask,
        input logic [7:0] exp);
        access(1'b0, 1'b0, {12'h000, ofs}, 8'h00);
        check({7'h00, bus2.rvalid, bus2.rdata & mask}, {8'h01, exp}, "read");
    endtask
    task automatic seq3(input logic [15:0] ad, input logic [7:0] d,
        input logic [7:0] c);
        access(1'b1, 1'b1, ad, d);
        wr(OFS_CMD, c);
        wr(OFS_STAT, 8'h80);
    endtask
    task automatic wait_start(input logic [15:0] ad);
        for (int i = 0; i < 200 && start2 !== 1'b1; i++)
            @(negedge clk_i);
        check({14'h0000, start2, busy2}, 16'h0003, "start pulse");
        check(adr2, ad, "launched address");
    endtask
    task automatic run_cpu(input logic [7:0] c, input logic [15:0] ad,
        input logic [7:0] d);
        cmd = c;
        adr = ad;
        dat = d;
        go = 1'b1;
        @(negedge clk_i);
        go = 1'b0;
        check(16'(busy1), 16'h0001, "cpu busy");
        for (int i = 0; i < 2000 && done !== 1'b1; i++)
            @(negedge clk_i);
        check({6'h00, busy1, err, cmd1}, {8'h00, c}, "cpu run");
        check({dat1, 8'h00}, {d, 8'h00}, "cpu data");
        check(adr1, ad, "cpu address");
    endtask
    initial
    begin
        #300us;
        n_mismatch++;
        end_of_test;
    end
    initial
    begin
        {bus2.req, bus2.we, bus2.arr_sel, bus2.addr, bus2.wdata} = '0;
        // Security byte is sampled at release, so each value needs a reset
        for (int k = 0; k < 4; k++)
        begin
            rstn_i = 1'b0;
            nv_sec = {k[1:0], 4'(k * 3), 2'(3 - k)};
            repeat (10) @(negedge clk_i);
            rstn_i = 1'b1;
            repeat (3) @(negedge clk_i);
            check(16'(key2), 16'(k == 2), "key enable");
            check(16'(sec2), 16'(k != 1), "secured");
            check(16'(flags2), 16'(k * 3), "user flags");
        end
        unlock = 1'b1;
        @(negedge clk_i);
        unlock = 1'b0;
        @(negedge clk_i);
        check(16'(sec2), 16'h0000, "unlock");
        rd(OFS_SEC, 8'h3F, 8'h26);
        rd(OFS_STAT, 8'hF0, 8'hC0);
        rd(OFS_DIV, 8'h80, 8'h00);
        wr(OFS_RSV, 8'hFF);
        rd(OFS_RSV, 8'hFF, 8'h00);
        check({8'h00, prot2}, {8'h00, nv_prot}, "protection");
        $display("test reset and security done");
        seq3(16'h1000, 8'h33, CMD_PROG);
        rd(OFS_STAT, 8'h10, 8'h10);
        check(16'(busy2), 16'h0000, "no execution");
        wr(OFS_STAT, 8'h30);
        wr(OFS_DIV, 8'h3F);
        rd(OFS_DIV, 8'hFF, 8'hBF);
        $display("test divider gate done");
        seq3(16'h1234, 8'h5A, CMD_PROG);
        wait_start(16'h1234);
        check({dat2, cmd2}, {8'h5A, CMD_PROG}, "held data");
        rd(OFS_STAT, 8'hC0, 8'h80);
        seq3(16'h2000, 8'h77, CMD_VERIFY);
        rd(OFS_STAT, 8'hC0, 8'h00);
        seq3(16'h3000, 8'h11, CMD_ERASE);
        rd(OFS_STAT, 8'h40, 8'h00);
        wait_start(16'h3000);
        check({8'h00, cmd2}, {8'h00, CMD_ERASE}, "overwritten cmd");
        rd(OFS_STAT, 8'h40, 8'h00);
        for (int i = 0; i < 100 && bus2.rdata[ST_DONE] !== 1'b1; i++)
            access(1'b0, 1'b0, {12'h000, OFS_STAT}, 8'h00);
        check(16'(bus2.rdata[ST_DONE]), 16'h0001, "complete");
        $display("test buffered commands done");
        access(1'b1, 1'b1, 16'h1000, 8'h44);
        wr(OFS_DIV, 8'h3F);
        rd(OFS_STAT, 8'h10, 8'h10);
        wr(OFS_STAT, 8'h30);
        // Protection byte leaves ranges closed, so mass erase is refused
        seq3(16'h1000, 8'h00, CMD_MASS);
        rd(OFS_STAT, 8'h30, 8'h20);
        check(16'(busy2), 16'h0000, "mass blocked");
        wr(OFS_STAT, 8'h30);
        $display("test aborted sequence done");
        run_cpu(CMD_PROG, 16'h4000, 8'hA5);
        run_cpu(CMD_ERASE, 16'h8000, 8'h3C);
        $display("test cpu end done");
        end_of_test;
    end
endmodule // flash_command_controller_test
`default_nettype wire
